// *** rtl/acs_pkg.sv ***
`default_nettype none
package acs_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS  = 128;
  localparam int SLOT_IDX_W = 7;
  localparam int CHAN_W     = 4;
  localparam int ADDR_W     = 12;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [2:0]        SLOT_REGION = 3'h1;   // Address bits 11:9, slots at 0x200
  localparam int SLOT_IDX_LSB = 2;

  // Control fields
  localparam int CTRL_STD_BIT = 0;
  localparam int CTRL_TEMP_BIT = 1;
  localparam int CTRL_CNT_LSB = 8;
  localparam logic       CTRL_STD_RST  = 1'b1;
  localparam logic       CTRL_TEMP_RST = 1'b0;
  localparam logic [6:0] CTRL_CNT_RST  = 7'h00;
  localparam logic [3:0] SLOT_RST      = 4'h0;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_POS_LSB  = 8;
  localparam int STAT_TEMP_BIT = 15;
  localparam int STAT_CHAN_LSB = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS  = 400;
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SLOT_IDX_W-1:0] last_slot;
    logic                  temp_en;
    logic                  std_sel;
  } acs_ctrl_t;

  typedef struct packed {
    logic [SLOT_IDX_W-1:0] pos;
    logic                  temp_phase;
  } acs_ptr_t;
endpackage : acs_pkg
`default_nettype wire

// *** rtl/acs_next_pos.sv ***
`timescale 1ns/1ns
`default_nettype none
module acs_next_pos
  import acs_pkg::*;
(
  input  wire acs_ptr_t  cur,       // Current sequence position
  input  wire acs_ctrl_t ctrl,      // Sequencer settings
  output acs_ptr_t       nxt        // Position after one conversion
);
  // ----------------------------------------------------------------
  // Step one position, wrapping after the last slot or temperature
  // ----------------------------------------------------------------
  // Greater-or-equal guards a slot count lowered below the pointer
  always_comb begin
    nxt = '0;
    if (cur.temp_phase) begin
      nxt = '0;
    end else if (cur.pos >= ctrl.last_slot) begin
      if (ctrl.temp_en) begin
        nxt.pos        = cur.pos;
        nxt.temp_phase = 1'b1;
      end else begin
        nxt = '0;
      end
    end else begin
      nxt.pos = cur.pos + 7'h01;
    end
  end
endmodule : acs_next_pos
`default_nettype wire

// *** rtl/acs_sequencer.sv ***
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
)(
  input  wire logic              CLOCK,          // 25 MHz clock
  input  wire logic              RST_N,          // Synchronous reset, low
  input  wire logic              CONV_START,     // Conversion start pulse
  output logic [CHAN_W-1:0]      MUX_CHANNEL,    // Analog input selected
  output logic                   MUX_TEMP_SEL,   // Temperature sensor selected
  output logic [SLOT_IDX_W-1:0]  SEQ_POS,        // Current sequence position
  output logic                   CONV_BUSY,      // Conversion phase running
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,   // Write address
  input  wire logic              S_AXI_AWVALID,  // Write address valid
  output logic                   S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0]       S_AXI_WDATA,    // Write data
  input  wire logic [3:0]        S_AXI_WSTRB,    // Write byte strobes
  input  wire logic              S_AXI_WVALID,   // Write data valid
  output logic                   S_AXI_WREADY,   // Write data ready
  output logic [1:0]             S_AXI_BRESP,    // Write response
  output logic                   S_AXI_BVALID,   // Write response valid
  input  wire logic              S_AXI_BREADY,   // Write response ready
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,   // Read address
  input  wire logic              S_AXI_ARVALID,  // Read address valid
  output logic                   S_AXI_ARREADY,  // Read address ready
  output logic [31:0]            S_AXI_RDATA,    // Read data
  output logic [1:0]             S_AXI_RRESP,    // Read response
  output logic                   S_AXI_RVALID,   // Read data valid
  input  wire logic              S_AXI_RREADY    // Read data ready
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYC);

  acs_ctrl_t           ctrl_r, ctrl_nxt;
  logic [CHAN_W-1:0]   slot_r [NUM_SLOTS];
  acs_ptr_t            ptr_r, ptr_nxt, ptr_step;
  logic                busy_r, busy_nxt;
  logic [CNT_W-1:0]    cnt_r, cnt_nxt;
  logic [CHAN_W-1:0]   chan_r, chan_nxt;
  logic                tsel_r, tsel_nxt;

  logic                awready_r, awready_nxt, wready_r, wready_nxt;
  logic                aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0]   awaddr_r, awaddr_nxt;
  logic [31:0]         wdata_r, wdata_nxt;
  logic [3:0]          wstrb_r, wstrb_nxt;
  logic                bvalid_r, bvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt;
  logic                arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [1:0]          rresp_r, rresp_nxt;

  logic                do_write, wr_slot, conv_end;
  logic [SLOT_IDX_W-1:0] wr_idx, rd_idx;

  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  // Misaligned slot writes answer with an error, so they must not land either
  assign wr_slot  = do_write && (awaddr_r[11:9] == SLOT_REGION) && wstrb_r[0] &&
                    (awaddr_r[1:0] == 2'h0);
  assign wr_idx   = awaddr_r[SLOT_IDX_LSB +: SLOT_IDX_W];
  assign rd_idx   = S_AXI_ARADDR[SLOT_IDX_LSB +: SLOT_IDX_W];
  assign conv_end = busy_r && (cnt_r == 8'h01);

  acs_next_pos u_next (
    .cur  (ptr_r),
    .ctrl (ctrl_r),
    .nxt  (ptr_step)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; response after both
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (S_AXI_AWVALID && awready_r) begin
      aw_got_nxt  = 1'b1;
      awaddr_nxt  = S_AXI_AWADDR;
      awready_nxt = 1'b0;
    end
    if (S_AXI_WVALID && wready_r) begin
      w_got_nxt  = 1'b1;
      wdata_nxt  = S_AXI_WDATA;
      wstrb_nxt  = S_AXI_WSTRB;
      wready_nxt = 1'b0;
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      if (awaddr_r[1:0] != 2'h0) begin
        bresp_nxt = RESP_SLVERR;
      end else if (awaddr_r == CTRL_OFS || awaddr_r == STATUS_OFS ||
                   awaddr_r[11:9] == SLOT_REGION) begin
        bresp_nxt = RESP_OKAY;
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
  end

  // Control register; status is read only and ignores writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (do_write && awaddr_r == CTRL_OFS) begin
      if (wstrb_r[0]) begin
        ctrl_nxt.std_sel = wdata_r[CTRL_STD_BIT];
        ctrl_nxt.temp_en = wdata_r[CTRL_TEMP_BIT];
      end
      if (wstrb_r[1]) begin
        ctrl_nxt.last_slot = wdata_r[CTRL_CNT_LSB +: SLOT_IDX_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Data is sampled at the address handshake, so status is one cycle old
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (S_AXI_ARVALID && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = 32'h0000_0000;
      rresp_nxt   = RESP_OKAY;
      if (S_AXI_ARADDR[1:0] != 2'h0) begin
        rresp_nxt = RESP_SLVERR;
      end else if (S_AXI_ARADDR == CTRL_OFS) begin
        rdata_nxt[CTRL_STD_BIT]                 = ctrl_r.std_sel;
        rdata_nxt[CTRL_TEMP_BIT]                = ctrl_r.temp_en;
        rdata_nxt[CTRL_CNT_LSB +: SLOT_IDX_W]   = ctrl_r.last_slot;
      end else if (S_AXI_ARADDR == STATUS_OFS) begin
        rdata_nxt[STAT_BUSY_BIT]                = busy_r;
        rdata_nxt[STAT_POS_LSB +: SLOT_IDX_W]   = ptr_r.pos;
        rdata_nxt[STAT_TEMP_BIT]                = ptr_r.temp_phase;
        rdata_nxt[STAT_CHAN_LSB +: CHAN_W]      = chan_r;
      end else if (S_AXI_ARADDR[11:9] == SLOT_REGION) begin
        rdata_nxt[CHAN_W-1:0] = slot_r[rd_idx];
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Conversion timing and sequence pointer
  // ----------------------------------------------------------------
  // A start during a running conversion is ignored, so one start moves at most one step
  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt  = cnt_r;
    ptr_nxt  = ptr_r;
    if (CONV_START && !busy_r) begin
      busy_nxt = 1'b1;
      cnt_nxt  = CONV_LOAD;
    end else if (busy_r) begin
      cnt_nxt = cnt_r - 8'h01;
      if (conv_end) begin
        busy_nxt = 1'b0;
        ptr_nxt  = ptr_step;
      end
    end
    // Standard sequencer owns the mux; slot pointer parks at position zero
    if (ctrl_r.std_sel) begin
      ptr_nxt = '0;
    end
  end

  // Mux follows the pointer only between conversions
  always_comb begin
    chan_nxt = chan_r;
    tsel_nxt = tsel_r;
    if (!busy_nxt) begin
      tsel_nxt = ptr_nxt.temp_phase;
      chan_nxt = ptr_nxt.temp_phase ? 4'h0 : slot_r[ptr_nxt.pos];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctrl_r    <= '{last_slot: CTRL_CNT_RST, temp_en: CTRL_TEMP_RST, std_sel: CTRL_STD_RST};
      ptr_r     <= '0;
      busy_r    <= 1'b0;
      cnt_r     <= 8'h00;
      chan_r    <= 4'h0;
      tsel_r    <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      ptr_r     <= ptr_nxt;
      busy_r    <= busy_nxt;
      cnt_r     <= cnt_nxt;
      chan_r    <= chan_nxt;
      tsel_r    <= tsel_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Slot storage; only four bits kept, so no slot can name the sensor
  always_ff @(posedge CLOCK) begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (!RST_N) begin
        slot_r[i] <= SLOT_RST;
      end else if (wr_slot && wr_idx == SLOT_IDX_W'(i)) begin
        slot_r[i] <= wdata_r[CHAN_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign MUX_CHANNEL   = chan_r;
  assign MUX_TEMP_SEL  = tsel_r;
  assign SEQ_POS       = ptr_r.pos;
  assign CONV_BUSY     = busy_r;
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY  = wready_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;
  assign S_AXI_RVALID  = rvalid_r;
endmodule : acs_sequencer
`default_nettype wire

// *** verif/acs_sequencer_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_assertions
  import acs_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
)(
  input wire logic                  CLOCK,        // Clock
  input wire logic                  RST_N,        // Sync reset, low
  input wire logic                  CONV_START,   // Start request
  input wire logic [CHAN_W-1:0]     MUX_CHANNEL,  // Selected input
  input wire logic                  MUX_TEMP_SEL, // Sensor selected
  input wire logic [SLOT_IDX_W-1:0] SEQ_POS,      // Position
  input wire logic                  CONV_BUSY,    // Converting
  input wire logic                  S_AXI_BVALID, // Write answer
  input wire logic                  S_AXI_BREADY, // Write answer taken
  input wire logic                  S_AXI_RVALID, // Read answer
  input wire logic                  S_AXI_RREADY  // Read answer taken
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [7:0] busy_cnt_r;
  logic [7:0] busy_cnt_nxt;
  // Counter, since a repetition cannot take the parameter as its count
  always_comb busy_cnt_nxt = (RST_N && CONV_BUSY) ? busy_cnt_r + 8'h01 : 8'h00;
  always_ff @(posedge CLOCK) busy_cnt_r <= busy_cnt_nxt;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_conv_end;
    $fell(CONV_BUSY);
  endsequence
  sequence s_leave_temp;
    $fell(CONV_BUSY) && $past(MUX_TEMP_SEL);
  endsequence

  a_start_busy: assert property (CONV_START && !CONV_BUSY |=> CONV_BUSY)
    else $error("start did not begin a conversion");
  a_conv_len: assert property (s_conv_end |-> busy_cnt_r == CONV_CYC)
    else $error("conversion phase has wrong length");
  a_pos_moves: assert property ($changed(SEQ_POS) |-> $fell(CONV_BUSY))
    else $error("position moved outside a conversion end");
  a_step_one: assert property (s_conv_end ##0 (!$past(MUX_TEMP_SEL) && !MUX_TEMP_SEL
    && SEQ_POS != 7'h00) |-> SEQ_POS == $past(SEQ_POS) + 7'h01)
    else $error("position did not advance by one");
  a_temp_wrap: assert property (s_leave_temp |-> SEQ_POS == 7'h00 && !MUX_TEMP_SEL)
    else $error("no restart after sensor conversion");
  a_temp_entry: assert property ($rose(MUX_TEMP_SEL) |-> $fell(CONV_BUSY) && $stable(SEQ_POS))
    else $error("sensor selected at a wrong moment");
  a_temp_chan: assert property (MUX_TEMP_SEL |-> MUX_CHANNEL == 4'h0)
    else $error("input channel shown during sensor phase");
  a_mux_hold: assert property (CONV_BUSY && $past(CONV_BUSY) |-> $stable(MUX_CHANNEL)
    && $stable(MUX_TEMP_SEL))
    else $error("multiplexer moved during a conversion");
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped early");
  a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read answer dropped early");
endmodule : acs_sequencer_assertions

bind acs_sequencer acs_sequencer_assertions #(.CONV_CYC(CONV_CYC)) u_chk (.CLOCK, .RST_N,
  .CONV_START, .MUX_CHANNEL, .MUX_TEMP_SEL, .SEQ_POS, .CONV_BUSY, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_RVALID, .S_AXI_RREADY);
`default_nettype wire

// *** verif/acs_host_pacer.sv ***
`timescale 1ns/1ns
`default_nettype none
module acs_host_pacer (
  input  wire logic       clock, // Bench clock
  input  wire logic       busy,  // Conversion phase
  input  wire logic       go,    // Pacing allowed
  input  wire logic [7:0] num,   // Conversions to start
  input  wire logic [3:0] gap,   // Idle cycles before a start
  output logic            start  // Conversion start pulse
);
  int sent;
  // One start per idle phase; a start during busy would be dropped
  initial begin
    start = 1'b0;
    sent = 0;
    forever begin
      @(posedge clock);
      if (!go) sent = 0;
      else if (!busy && sent < int'(num)) begin
        repeat (gap) @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        sent++;
        @(posedge clock);
      end
    end
  end
endmodule : acs_host_pacer
`default_nettype wire

// *** verif/test_acs_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_acs_sequencer
  import acs_pkg::*;
;
  localparam int CC = 2;         // Short conversion keeps the run brief
  localparam int LIMIT = 20000;  // Cycle ceiling
  logic clock, rst_n, start, go, busy, temp_sel, busy_q;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [3:0] chan, gap;
  logic [3:0] slot[128];
  logic [6:0] pos;
  logic [7:0] num;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [31:0] exp_q[$];
  logic [1:0] bresp, rresp;
  int bad_count, num_checks, cycles, m_pos, m_last;
  int seed = 39038;
  logic m_temp, m_ten, m_std;    // Reference model of the sequence
  logic [1:0] resp;
  logic [31:0] rd_v, rnd;
  // Two sample rate example: fast inputs 5, 9, 14 around slow inputs 2 and 10
  localparam logic [3:0] TBL [11] = '{4'h5, 4'h9, 4'he, 4'h2, 4'h5, 4'h9,
                                      4'he, 4'ha, 4'h5, 4'h9, 4'he};

  acs_sequencer #(
    .CONV_CYC (CC)
  ) dut (
    .CLOCK         (clock),
    .RST_N         (rst_n),
    .CONV_START    (start),
    .MUX_CHANNEL   (chan),
    .MUX_TEMP_SEL  (temp_sel),
    .SEQ_POS       (pos),
    .CONV_BUSY     (busy),
    .S_AXI_AWADDR  (awaddr),
    .S_AXI_AWVALID (awvalid),
    .S_AXI_AWREADY (awready),
    .S_AXI_WDATA   (wdata),
    .S_AXI_WSTRB   (4'hf),
    .S_AXI_WVALID  (wvalid),
    .S_AXI_WREADY  (wready),
    .S_AXI_BRESP   (bresp),
    .S_AXI_BVALID  (bvalid),
    .S_AXI_BREADY  (bready),
    .S_AXI_ARADDR  (araddr),
    .S_AXI_ARVALID (arvalid),
    .S_AXI_ARREADY (arready),
    .S_AXI_RDATA   (rdata),
    .S_AXI_RRESP   (rresp),
    .S_AXI_RVALID  (rvalid),
    .S_AXI_RREADY  (rready)
  );

  acs_host_pacer u_host (
    .clock (clock),
    .busy  (busy),
    .go    (go),
    .num   (num),
    .gap   (gap),
    .start (start)
  );

  initial begin
    clock = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [31:0] ctrl_word(input logic s, input logic t, input int n);
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_STD_BIT] = s;
    ctrl_word[CTRL_TEMP_BIT] = t;
    ctrl_word[CTRL_CNT_LSB +: SLOT_IDX_W] = SLOT_IDX_W'(n);
  endfunction : ctrl_word

  function automatic logic [11:0] slot_addr(input int n);
    slot_addr = {SLOT_REGION, 9'h000} | 12'(n << SLOT_IDX_LSB);
  endfunction : slot_addr

  // Address and data offered together; bready held until the answer comes
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1'b1;
        r = bresp;
      end
    end
    bready <= 1'b0;
    @(posedge clock);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1'b1;
        v = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
    @(posedge clock);
  endtask : axi_read

  // Notes the position after each of n steps, then lets the host pace them
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      if (m_std || m_temp) begin
        m_pos  = 0;
        m_temp = 1'b0;
      end else if (m_pos >= m_last) begin
        if (m_ten) begin
          m_temp = 1'b1;
        end else begin
          m_pos = 0;
        end
      end else begin
        m_pos++;
      end
      exp_q.push_back({20'h0, m_temp, SLOT_IDX_W'(m_pos), m_temp ? 4'h0 : slot[m_pos]});
    end
    num <= 8'(n);
    go  <= 1'b1;
    while (exp_q.size() != 0) @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : run

  // ----------------------------------------------------------------
  // Watchers
  // ----------------------------------------------------------------
  // The mux state that stands after a conversion end is the next position
  always @(posedge clock) begin
    busy_q <= busy;
    if (rst_n && busy_q && !busy) begin
      if (exp_q.size() != 0) begin
        check({20'h0, temp_sel, pos, chan}, exp_q.pop_front());
      end else begin
        check({20'h0, temp_sel, pos, chan}, 32'hffff_ffff);
      end
    end
  end

  // A hang must still reach the verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("[FAIL] %0t cycle limit %h, notes left %h", $time, cycles, exp_q.size());
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n   <= 1'b0;
    go      <= 1'b0;
    num     <= 8'h00;
    gap     <= 4'h0;
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b0;
    arvalid <= 1'b0;
    rready  <= 1'b0;
    awaddr  <= 12'h000;
    araddr  <= 12'h000;
    wdata   <= 32'h0000_0000;
    m_pos  = 0;
    m_last = 0;
    m_temp = 1'b0;
    m_ten  = 1'b0;
    m_std  = 1'b1;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check({10'h000, chan, pos, busy, temp_sel, awready, wready, arready, bvalid, rvalid,
           bresp, rresp}, 32'h0000_01c0);
    check(rdata, 32'h0000_0000);
    axi_read(CTRL_OFS, rd_v, resp);
    check(rd_v, ctrl_word(CTRL_STD_RST, CTRL_TEMP_RST, int'(CTRL_CNT_RST)));
    for (int i = 0; i < 11; i++) begin
      slot[i] = TBL[i];
      axi_write(slot_addr(i), {28'h0, TBL[i]}, resp);
      check({30'h0, resp}, {30'h0, RESP_OKAY});
    end
    axi_read(slot_addr(3), rd_v, resp);
    check(rd_v, {28'h0, slot[3]});
    // Standard select still set: pointer parked at position zero
    run(3);
    m_std  = 1'b0;
    m_ten  = 1'b1;
    m_last = 10;
    axi_write(CTRL_OFS, ctrl_word(1'b0, 1'b1, 10), resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    axi_read(CTRL_OFS, rd_v, resp);
    check(rd_v, ctrl_word(m_std, m_ten, m_last));
    run(24);
    // Random slot contents, slot counts, sensor enable and pacing
    repeat (2) begin
      rnd = $random(seed);
      m_last = int'(rnd[2:0]);
      m_ten  = rnd[3];
      gap   <= rnd[7:4];
      for (int i = 0; i <= m_last; i++) begin
        rnd = $random(seed);
        slot[i] = rnd[3:0];
        axi_write(slot_addr(i), rnd, resp);
        check({30'h0, resp}, {30'h0, RESP_OKAY});
      end
      axi_write(CTRL_OFS, ctrl_word(1'b0, m_ten, m_last), resp);
      run(2 * m_last + 5);
    end
    // Refused and ignored accesses
    axi_write(12'h008, 32'hffff_ffff, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(slot_addr(0) | 12'h001, 32'h0000_000f, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(12'h001, 32'h0000_0001, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(STATUS_OFS, 32'hffff_ffff, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    axi_read(12'h00d, rd_v, resp);
    check(rd_v, 32'h0000_0000);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_read(slot_addr(0), rd_v, resp);
    check(rd_v, {28'h0, slot[0]});
    axi_read(CTRL_OFS, rd_v, resp);
    check(rd_v, ctrl_word(m_std, m_ten, m_last));
    axi_read(STATUS_OFS, rd_v, resp);
    check(rd_v, {12'h000, m_temp ? 4'h0 : slot[m_pos], m_temp, SLOT_IDX_W'(m_pos), 8'h00});
    tally_and_finish();
  end
endmodule : test_acs_sequencer
`default_nettype wire
